// ===== hw/dcog_pkg.sv
// Function
// (RULE1) Eight-wide standard groups, two-wide analog groups
// (RULE2) Four direction settings per group
// (RULE3) Groups one to six cover outputs 01-48
// (RULE4) Groups seven, eight cover outputs 51-54
// (RULE5) Direction input high up, low down
// (RULE6) Reset loads every group with both directions
// (RULE7) Window output takes group six direction alone
// (RULE8) Program reply outputs never direction restricted
// (RULE9) Direction change raises store pending until committed
// (RULE10) Display option: continuous or speed dependent
// (RULE11) Offset is desired minus actual, modulo resolution
// (RULE12) Offset only for rotary, single encoder units
// (RULE13) Offset resets to zero
// (RULE14) Faults detected, code shown on display
// (RULE15) Error forces outputs off, ready off
// (RULE16) Error cleared by reset or clear command
// (RULE17) Forbidden direction holds group outputs inactive
package dcog_pkg;

    localparam int ADDR_W      = 8;
    localparam int DATA_W      = 32;
    localparam int POS_W       = 16;
    localparam int CODE_W      = 8;
    localparam int STD_GROUPS  = 6;
    localparam int STD_W       = 8;
    localparam int ANA_GROUPS  = 2;
    localparam int ANA_W       = 2;
    localparam int ALL_GROUPS  = STD_GROUPS + ANA_GROUPS;
    localparam int STD_OUTS    = STD_GROUPS * STD_W;
    localparam int ANA_OUTS    = ANA_GROUPS * ANA_W;
    localparam int DIR_W       = 2 * ALL_GROUPS;
    localparam int CFG_W       = 4;
    localparam int SYNC_W      = POS_W + 2;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_DIR_CFG  = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CONFIG   = 8'h04;
    localparam logic [ADDR_W-1:0] REG_OFFSET   = 8'h08;
    localparam logic [ADDR_W-1:0] REG_RESOL    = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_NULLSET  = 8'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h14;
    localparam logic [ADDR_W-1:0] REG_COMMAND  = 8'h18;
    localparam logic [ADDR_W-1:0] REG_POSITION = 8'h1c;

    // Config fields
    localparam int CFG_ROTARY_BIT = 0;
    localparam int CFG_CONT_BIT   = 1;
    localparam int CFG_PWIN_BIT   = 2;
    localparam int CFG_PWIN48_BIT = 3;

    // Status fields
    localparam int ST_ERR_BIT   = 0;
    localparam int ST_STORE_BIT = 1;
    localparam int ST_UP_BIT    = 2;
    localparam int ST_READY_BIT = 3;
    localparam int ST_ANA_BIT   = 4;
    localparam int ST_MULTI_BIT = 5;
    localparam int ST_CODE_LSB  = 8;

    // Command fields
    localparam int CMD_CLR_ERR_BIT = 0;
    localparam int CMD_COMMIT_BIT  = 1;

    // Reset values
    localparam logic [DIR_W-1:0]  DIR_RESET    = 16'h0000;
    localparam logic [CFG_W-1:0]  CFG_RESET    = 4'h1;
    localparam logic [POS_W-1:0]  OFFSET_RESET = 16'h0000;
    localparam logic [POS_W-1:0]  RESOL_RESET  = 16'h0168;

    // Group layout for window and program reply outputs
    localparam int          GRP_THREE   = 2;
    localparam int          GRP_SIX     = 5;
    localparam logic [STD_W-1:0] REPLY_MASK = 8'h7f;

    // Error codes
    localparam logic [CODE_W-1:0] ERR_NONE    = 8'h00;
    localparam logic [CODE_W-1:0] ERR_ENCODER = 8'h0a;
    localparam logic [CODE_W-1:0] ERR_RANGE   = 8'h0b;

    typedef enum logic [1:0] {
        DCOG_BOTH_DIRECTIONS,
        DCOG_UP_ONLY,
        DCOG_DOWN_ONLY,
        DCOG_NEVER
    } dcog_dir_t;

endpackage

// ===== hw/dcog_gate_if.sv
`timescale 1ns/1ps
interface dcog_gate_if
    import dcog_pkg::*;
#(
    parameter int N = 8
);
    dcog_dir_t      mode;
    logic           up;
    logic [N-1:0]   cam;
    logic [N-1:0]   exempt;
    logic [N-1:0]   gated;

    modport ctrl (output mode, output up, output cam, output exempt, input gated);
    modport gate (input mode, input up, input cam, input exempt, output gated);
endinterface

// ===== hw/dcog_group_gate.sv
`timescale 1ns/1ps
module dcog_group_gate
    import dcog_pkg::*;
#(
    parameter int N = 8
) (
    dcog_gate_if.gate gi
);
    logic permit;

    always_comb begin
        case (gi.mode)
            DCOG_BOTH_DIRECTIONS: permit = 1'b1;          // RULE2
            DCOG_UP_ONLY:         permit = gi.up;         // RULE5
            DCOG_DOWN_ONLY:       permit = ~gi.up;        // RULE5
            DCOG_NEVER:           permit = 1'b0;          // RULE2
            default:              permit = 1'b0;
        endcase
    end

    // Exempt bits pass whatever the direction
    assign gi.gated = gi.cam & ({N{permit}} | gi.exempt);  // RULE17 RULE8
endmodule

// ===== hw/dcog_top.sv
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module dcog_top
    import dcog_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                arst_n,
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [DATA_W-1:0]   reg_rdata,
    input  wire logic [POS_W-1:0]    enc_pos_pin,
    input  wire logic                enc_dir_pin,
    input  wire logic                enc_fault_pin,
    input  wire logic                strap_analog,
    input  wire logic                strap_multi,
    input  wire logic [STD_OUTS-1:0] cam_in,
    input  wire logic [ANA_OUTS-1:0] analog_cam_in,
    input  wire logic [CODE_W-1:0]   sys_fault_code,
    output logic      [STD_OUTS-1:0] cam_out,
    output logic      [ANA_OUTS-1:0] analog_out,
    output logic                     ready_out,
    output logic                     store_pending_out,
    output logic                     disp_continuous,
    output logic                     disp_error,
    output logic      [POS_W-1:0]    disp_value,
    output logic      [POS_W-1:0]    position_out
);

    // Pin synchroniser, three stages
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] sync3_reg;
    logic [SYNC_W-1:0] pins_reg;

    logic [DIR_W-1:0]  dir_cfg_reg;
    logic [CFG_W-1:0]  cfg_reg;
    logic [POS_W-1:0]  offset_reg;
    logic [POS_W-1:0]  resol_reg;
    logic              store_reg;
    logic              error_reg;
    logic [CODE_W-1:0] code_reg;
    logic              strap_done_reg;
    logic              analog_variant_reg;
    logic              multi_encoder_reg;

    logic [POS_W-1:0]  raw_pos;
    logic              dir_up;
    logic              enc_fault;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            pins_reg  <= '0;
        end else begin
            sync1_reg <= {enc_fault_pin, enc_dir_pin, enc_pos_pin};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            // A word in transit between codes is not taken
            if (sync2_reg == sync3_reg) begin
                pins_reg <= sync3_reg;
            end
        end
    end

    assign raw_pos   = pins_reg[POS_W-1:0];
    assign dir_up    = pins_reg[POS_W];                    // RULE5
    assign enc_fault = pins_reg[POS_W+1];

    // Straps are static; caught once in the first cycle after release
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            strap_done_reg     <= 1'b0;
            analog_variant_reg <= 1'b0;
            multi_encoder_reg  <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg     <= 1'b1;
            analog_variant_reg <= strap_analog;
            multi_encoder_reg  <= strap_multi;
        end
    end

    // Register writes
    logic wr_dir;
    logic wr_cfg;
    logic wr_off;
    logic wr_res;
    logic wr_null;
    logic wr_cmd;
    logic clr_err;
    logic commit;
    logic offset_active;
    logic range_err;

    assign wr_dir  = reg_wr && (reg_addr == REG_DIR_CFG);
    assign wr_cfg  = reg_wr && (reg_addr == REG_CONFIG);
    assign wr_off  = reg_wr && (reg_addr == REG_OFFSET);
    assign wr_res  = reg_wr && (reg_addr == REG_RESOL);
    assign wr_null = reg_wr && (reg_addr == REG_NULLSET);
    assign wr_cmd  = reg_wr && (reg_addr == REG_COMMAND);
    assign clr_err = wr_cmd && reg_wdata[CMD_CLR_ERR_BIT];
    assign commit  = wr_cmd && reg_wdata[CMD_COMMIT_BIT];

    assign offset_active = cfg_reg[CFG_ROTARY_BIT] && !multi_encoder_reg;  // RULE12
    assign range_err     = (raw_pos >= resol_reg);

    // Nullpoint: desired minus actual, wrapped to resolution
    logic [POS_W:0]   ns_sum;
    logic [POS_W:0]   ns_wrap;
    logic [POS_W-1:0] desired;
    logic             null_ok;

    assign desired = reg_wdata[POS_W-1:0];
    assign ns_sum  = {1'b0, desired} + {1'b0, resol_reg} - {1'b0, raw_pos};        // RULE11
    assign ns_wrap = (ns_sum >= {1'b0, resol_reg}) ? ns_sum - {1'b0, resol_reg} : ns_sum;
    // Only with a valid actual value and a reachable target
    assign null_ok = wr_null && offset_active && !range_err && (desired < resol_reg);

    logic dir_change;
    logic cfg_change;
    logic off_change;

    assign dir_change = wr_dir && (reg_wdata[DIR_W-1:0] != dir_cfg_reg);
    assign cfg_change = (wr_cfg && (reg_wdata[CFG_W-1:0] != cfg_reg))
                        || (wr_res && (reg_wdata[POS_W-1:0] != resol_reg));
    assign off_change = (wr_off && (reg_wdata[POS_W-1:0] != offset_reg))
                        || (null_ok && (ns_wrap[POS_W-1:0] != offset_reg));

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dir_cfg_reg <= DIR_RESET;                      // RULE6
        end else if (wr_dir) begin
            dir_cfg_reg <= reg_wdata[DIR_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg_reg   <= CFG_RESET;
            resol_reg <= RESOL_RESET;
        end else begin
            if (wr_cfg) begin
                cfg_reg <= reg_wdata[CFG_W-1:0];
            end
            if (wr_res) begin
                resol_reg <= reg_wdata[POS_W-1:0];
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            offset_reg <= OFFSET_RESET;                    // RULE13
        end else if (null_ok) begin
            offset_reg <= ns_wrap[POS_W-1:0];              // RULE11
        end else if (wr_off) begin
            offset_reg <= reg_wdata[POS_W-1:0];
        end
    end

    // Store pending; a change in the commit cycle keeps it raised
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            store_reg <= 1'b0;
        end else if (dir_change || cfg_change || off_change) begin
            store_reg <= 1'b1;                             // RULE9
        end else if (commit) begin
            store_reg <= 1'b0;
        end
    end

    // Error detection and latch; a new fault beats the clear
    logic              err_det;
    logic [CODE_W-1:0] err_code;

    always_comb begin
        err_code = ERR_NONE;
        if (enc_fault) begin
            err_code = ERR_ENCODER;
        end else if (range_err) begin
            err_code = ERR_RANGE;
        end else if (sys_fault_code != ERR_NONE) begin
            err_code = sys_fault_code;
        end
    end

    assign err_det = (err_code != ERR_NONE);               // RULE14

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            error_reg <= 1'b0;
            code_reg  <= ERR_NONE;
        end else if (err_det) begin
            error_reg <= 1'b1;
            if (!error_reg || clr_err) begin
                code_reg <= err_code;
            end
        end else if (clr_err) begin
            error_reg <= 1'b0;                             // RULE16
            code_reg  <= ERR_NONE;
        end
    end

    // Corrected position
    logic [POS_W-1:0] eff_offset;
    logic [POS_W:0]   pos_sum;
    logic [POS_W:0]   pos_wrap;

    assign eff_offset = offset_active ? offset_reg : OFFSET_RESET;                 // RULE12
    assign pos_sum    = {1'b0, raw_pos} + {1'b0, eff_offset};                      // RULE11
    assign pos_wrap   = (pos_sum >= {1'b0, resol_reg}) ? pos_sum - {1'b0, resol_reg} : pos_sum;

    // Direction gating per group
    dcog_dir_t         group_mode [ALL_GROUPS];
    logic [STD_W-1:0]  exempt     [STD_GROUPS];
    logic [STD_OUTS-1:0] std_gated;
    logic [ANA_OUTS-1:0] ana_gated;

    always_comb begin
        for (int i = 0; i < ALL_GROUPS; i++) begin
            group_mode[i] = dcog_dir_t'(dir_cfg_reg[2*i +: 2]);                    // RULE2
        end
        for (int i = 0; i < STD_GROUPS; i++) begin
            exempt[i] = '0;
        end
        if (cfg_reg[CFG_PWIN_BIT]) begin
            if (cfg_reg[CFG_PWIN48_BIT]) begin
                exempt[GRP_SIX] = REPLY_MASK;                                      // RULE7 RULE8
            end else begin
                // Window on output 24 follows group six
                group_mode[GRP_THREE] = dcog_dir_t'(dir_cfg_reg[2*GRP_SIX +: 2]);  // RULE7
                exempt[GRP_THREE]     = REPLY_MASK;                                // RULE8
            end
        end
    end

    genvar g;
    for (g = 0; g < STD_GROUPS; g++) begin : g_std
        dcog_gate_if #(.N(STD_W)) gif ();
        dcog_group_gate #(.N(STD_W)) u_gate (.gi(gif));
        assign gif.mode   = group_mode[g];
        assign gif.up     = dir_up;
        assign gif.cam    = cam_in[g*STD_W +: STD_W];                              // RULE3
        assign gif.exempt = exempt[g];
        assign std_gated[g*STD_W +: STD_W] = gif.gated;                            // RULE1
    end

    for (g = 0; g < ANA_GROUPS; g++) begin : g_ana
        dcog_gate_if #(.N(ANA_W)) gif ();
        dcog_group_gate #(.N(ANA_W)) u_gate (.gi(gif));
        assign gif.mode   = group_mode[STD_GROUPS + g];
        assign gif.up     = dir_up;
        assign gif.cam    = analog_cam_in[g*ANA_W +: ANA_W];                       // RULE4
        assign gif.exempt = '0;
        assign ana_gated[g*ANA_W +: ANA_W] = gif.gated;                            // RULE1
    end

    // Output stage: an error kills all switching and the ready line
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cam_out    <= '0;
            analog_out <= '0;
            ready_out  <= 1'b0;
        end else begin
            cam_out    <= error_reg ? '0 : std_gated;                              // RULE15
            analog_out <= (error_reg || !analog_variant_reg) ? '0 : ana_gated;     // RULE15 RULE4
            ready_out  <= !error_reg;                                              // RULE15
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            store_pending_out <= 1'b0;
            disp_continuous   <= 1'b0;
            disp_error        <= 1'b0;
            disp_value        <= '0;
            position_out      <= '0;
        end else begin
            store_pending_out <= store_reg;
            disp_continuous   <= cfg_reg[CFG_CONT_BIT];                            // RULE10
            disp_error        <= error_reg;                                        // RULE14
            disp_value        <= error_reg ? POS_W'(code_reg) : pos_wrap[POS_W-1:0];
            position_out      <= pos_wrap[POS_W-1:0];
        end
    end

    // Read port
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] status_word;

    always_comb begin
        status_word = '0;
        status_word[ST_ERR_BIT]   = error_reg;
        status_word[ST_STORE_BIT] = store_reg;
        status_word[ST_UP_BIT]    = dir_up;
        status_word[ST_READY_BIT] = ready_out;
        status_word[ST_ANA_BIT]   = analog_variant_reg;
        status_word[ST_MULTI_BIT] = multi_encoder_reg;
        status_word[ST_CODE_LSB +: CODE_W] = code_reg;
    end

    always_comb begin
        case (reg_addr)
            REG_DIR_CFG:  rd_mux = DATA_W'(dir_cfg_reg);
            REG_CONFIG:   rd_mux = DATA_W'(cfg_reg);
            REG_OFFSET:   rd_mux = DATA_W'(offset_reg);
            REG_RESOL:    rd_mux = DATA_W'(resol_reg);
            REG_STATUS:   rd_mux = status_word;
            REG_POSITION: rd_mux = DATA_W'(pos_wrap[POS_W-1:0]);
            default:      rd_mux = '0;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_error_outputs_off: assert property (error_reg |=> (cam_out == '0) && !ready_out) // RULE15
        else $error("outputs active during error");
    a_ready_when_clean: assert property (!error_reg ##1 !error_reg |-> ##1 ready_out)  // RULE15
        else $error("ready low without error");
    a_never_blocks_one: assert property (!error_reg && group_mode[0] == DCOG_NEVER     // RULE2
                                         |=> cam_out[STD_W-1:0] == '0)
        else $error("group one switched while never");
    a_up_only_down: assert property (!error_reg && group_mode[1] == DCOG_UP_ONLY       // RULE17
                                     && !dir_up |=> cam_out[2*STD_W-1:STD_W] == '0)
        else $error("up-only group switched counting down");
    a_both_passes: assert property (!error_reg && group_mode[3] == DCOG_BOTH_DIRECTIONS // RULE2
                                    |=> cam_out[4*STD_W-1:3*STD_W]
                                        == $past(cam_in[4*STD_W-1:3*STD_W]))
        else $error("both-direction group not passing cams");
    a_reply_always: assert property (!error_reg && cfg_reg[CFG_PWIN_BIT]              // RULE8
                                     && cfg_reg[CFG_PWIN48_BIT]
                                     |=> cam_out[STD_OUTS-2:STD_OUTS-STD_W]
                                         == $past(cam_in[STD_OUTS-2:STD_OUTS-STD_W]))
        else $error("program reply outputs restricted");
    a_window_gated: assert property (!error_reg && cfg_reg[CFG_PWIN_BIT]              // RULE7
                                     && cfg_reg[CFG_PWIN48_BIT]
                                     && group_mode[GRP_SIX] == DCOG_NEVER
                                     |=> !cam_out[STD_OUTS-1])
        else $error("window output ignores group six");
    a_store_raised: assert property (dir_change |=> store_reg                         // RULE9
                                     ##1 (store_reg || $past(commit)))
        else $error("store pending not raised");
    a_offset_bypass: assert property (!offset_active && resol_reg > raw_pos           // RULE12
                                      |=> position_out == $past(raw_pos))
        else $error("offset applied when inactive");
    a_error_clears: assert property (error_reg && clr_err && !err_det |=> !error_reg) // RULE16
        else $error("error not cleared");
    a_error_latches: assert property (err_det |=> error_reg && disp_error == $past(error_reg)) // RULE14
        else $error("fault not latched");

    c_error_cleared: cover property (error_reg ##1 clr_err ##1 !error_reg);
    c_nullpoint: cover property (null_ok ##1 offset_reg != OFFSET_RESET);
    c_group_blocked: cover property (group_mode[0] == DCOG_DOWN_ONLY && dir_up && cam_in[0]);
    c_store_commit: cover property (store_reg ##1 commit ##1 !store_reg);

endmodule

// ===== sim/dcog_enc_model.sv
`timescale 1ns/1ps
module dcog_enc_model #(
    parameter int RES = 360
) (
    input  wire logic        clock,
    input  wire logic        step,
    input  wire logic        dir_set,
    input  wire logic        fault_set,
    input  wire logic        load,
    input  wire logic [15:0] load_val,
    output logic      [15:0] enc_pos_pin,
    output logic             enc_dir_pin,
    output logic             enc_fault_pin
);
    logic [15:0] pos_reg = 16'h0000;
    // One count per eight clocks: a shaft is far slower than the logic, and a word
    // that changed on every clock would never settle through the synchroniser
    logic [2:0]  div_reg = 3'h0;
    always @(posedge clock) begin
        div_reg <= div_reg + 3'h1;
        if (load) begin
            pos_reg <= load_val;
        end else if (step && dir_set && div_reg == 3'h7) begin
            pos_reg <= (pos_reg == 16'(RES - 1)) ? 16'h0000 : pos_reg + 16'h0001;
        end else if (step && div_reg == 3'h7) begin
            pos_reg <= (pos_reg == 16'h0000) ? 16'(RES - 1) : pos_reg - 16'h0001;
        end
    end
    // Pins lag the edge like a real cable, so the design must synchronise them
    assign #1 enc_pos_pin   = pos_reg;
    assign #1 enc_dir_pin   = dir_set;
    assign #1 enc_fault_pin = fault_set;
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
    import dcog_pkg::*;
    logic clock = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata;
    logic [15:0] enc_pos, disp_value, position_out, load_val = 16'h0;
    logic enc_dir, enc_fault, ready_out, store_pending_out, disp_continuous, disp_error;
    logic strap_analog = 1'b1, strap_multi = 1'b0, step = 1'b1, dir_set = 1'b1;
    logic fault_set = 1'b0, load = 1'b0, cam_req = 1'b0, rd_d = 1'b0, cam_d = 1'b0;
    logic [47:0] cam_in = 48'h0, cam_out;
    logic [3:0] analog_cam_in = 4'h0, analog_out;
    logic [7:0] sys_fault_code = 8'h00;
    logic [31:0] rd_q[$];
    logic [51:0] cam_q[$];
    int err_total = 0, check_count = 0, cyc = 0;

    always #2.5 clock = ~clock;

    dcog_enc_model i_enc (.clock(clock), .step(step), .dir_set(dir_set),
        .fault_set(fault_set), .load(load), .load_val(load_val), .enc_pos_pin(enc_pos),
        .enc_dir_pin(enc_dir), .enc_fault_pin(enc_fault));

    dcog_top i_dut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .enc_pos_pin(enc_pos), .enc_dir_pin(enc_dir), .enc_fault_pin(enc_fault),
        .strap_analog(strap_analog), .strap_multi(strap_multi), .cam_in(cam_in),
        .analog_cam_in(analog_cam_in), .sys_fault_code(sys_fault_code),
        .cam_out(cam_out), .analog_out(analog_out), .ready_out(ready_out),
        .store_pending_out(store_pending_out), .disp_continuous(disp_continuous),
        .disp_error(disp_error), .disp_value(disp_value), .position_out(position_out));

    task automatic check(input logic [51:0] seen, input logic [51:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge clock);
        reg_rd <= 1'b0;
    endtask

    task automatic drive(input logic [47:0] c, input logic [3:0] a, input logic [51:0] e);
        @(posedge clock);
        cam_in <= c;
        analog_cam_in <= a;
        cam_req <= 1'b1;
        cam_q.push_back(e);
        @(posedge clock);
        cam_req <= 1'b0;
    endtask

    function automatic logic allow(input logic [1:0] m, input logic d);
        return m == DCOG_BOTH_DIRECTIONS || (m == DCOG_UP_ONLY && d) ||
               (m == DCOG_DOWN_ONLY && !d);
    endfunction

    // Results land one cycle after the request edge, so compare one edge later still
    always @(posedge clock) begin
        rd_d <= reg_rd;
        cam_d <= cam_req;
        if (rd_d && rd_q.size() > 0) check(52'(reg_rdata), 52'(rd_q.pop_front()));
        if (cam_d && cam_q.size() > 0) check({analog_out, cam_out}, cam_q.pop_front());
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        logic [15:0] cfg;
        logic [47:0] c;
        logic [3:0] a;
        logic [51:0] e;
        logic [7:0] code;
        logic d;
        void'($urandom(6420));
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        repeat (6) @(posedge clock);
        rd(REG_DIR_CFG, 32'h0);
        rd(REG_OFFSET, 32'h0);
        rd(8'h20, 32'h0);
        check(52'(ready_out), 52'h1);
        for (int it = 0; it < 16; it++) begin
            cfg = 16'($urandom());
            d = 1'($urandom());
            dir_set <= d;
            wr(REG_DIR_CFG, {16'h0, cfg});
            repeat (6) @(posedge clock);
            c = {16'($urandom()), $urandom()};
            a = 4'($urandom());
            for (int g = 0; g < STD_GROUPS; g++)
                e[g*8 +: 8] = allow(cfg[2*g +: 2], d) ? c[g*8 +: 8] : 8'h00;
            for (int g = 0; g < ANA_GROUPS; g++)
                e[48+2*g +: 2] = allow(cfg[12+2*g +: 2], d) ? a[2*g +: 2] : 2'b00;
            drive(c, a, e);
        end
        wr(REG_DIR_CFG, 32'h0c00);
        wr(REG_CONFIG, 32'hd);
        drive(48'hffff_ffff_ffff, 4'h0, 52'h7fff_ffff_ffff);
        wr(REG_CONFIG, 32'h5);
        drive(48'hff_ffff, 4'h0, 52'h7f_ffff);
        wr(REG_CONFIG, 32'h3);
        repeat (2) @(posedge clock);
        check(52'(disp_continuous), 52'h1);
        wr(REG_CONFIG, 32'h1);
        wr(REG_COMMAND, 32'h2);
        repeat (2) @(posedge clock);
        check(52'(store_pending_out), 52'h0);
        wr(REG_DIR_CFG, 32'h0c00);
        repeat (2) @(posedge clock);
        check(52'(store_pending_out), 52'h0);
        wr(REG_DIR_CFG, 32'h0);
        repeat (2) @(posedge clock);
        check(52'(store_pending_out), 52'h1);
        step <= 1'b0;
        load <= 1'b1;
        load_val <= 16'd100;
        @(posedge clock);
        load <= 1'b0;
        repeat (8) @(posedge clock);
        wr(REG_NULLSET, 32'd150);
        rd(REG_OFFSET, 32'd50);
        rd(REG_POSITION, 32'd150);
        check({position_out, disp_value}, {16'd150, 16'd150});
        wr(REG_NULLSET, 32'd50);
        rd(REG_OFFSET, 32'd310);
        wr(REG_CONFIG, 32'h0);
        wr(REG_NULLSET, 32'd200);
        rd(REG_OFFSET, 32'd310);
        wr(REG_CONFIG, 32'h1);
        code = 8'($urandom_range(255, 1));
        sys_fault_code <= code;
        drive(48'hffff_ffff_ffff, 4'hf, 52'h0);
        // Let the outputs launched at the last edge settle before looking
        @(posedge clock);
        check({ready_out, disp_error, disp_value}, {2'b01, 8'h0, code});
        sys_fault_code <= 8'h00;
        wr(REG_COMMAND, 32'h1);
        repeat (3) @(posedge clock);
        check(52'(ready_out), 52'h1);
        fault_set <= 1'b1;
        repeat (8) @(posedge clock);
        check({ready_out, disp_value}, {1'b0, 16'h000a});
        fault_set <= 1'b0;
        repeat (6) @(posedge clock);
        wr(REG_COMMAND, 32'h1);
        repeat (3) @(posedge clock);
        check(52'(ready_out), 52'h1);
        drive(48'h1234_5678_9abc, 4'h5, 52'h5_1234_5678_9abc);
        // Non-default groups, so the read after reset shows the reset really acted
        wr(REG_DIR_CFG, 32'h5555);
        cam_in <= '0;
        arst_n <= 1'b0;
        strap_multi <= 1'b1;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        repeat (8) @(posedge clock);
        rd(REG_DIR_CFG, 32'h0);
        wr(REG_NULLSET, 32'd150);
        rd(REG_OFFSET, 32'h0);
        repeat (4) @(posedge clock);
        close_out();
    end
endmodule
